// ==== brd_pkg.sv ====
// brd_pkg: constants and carrier types of the boot remap address decoder
// assumes one system clock; all masters share one address map except the boot alias, seen by masters 0 and 1 only
// Function
// - sixteen 256 Mbyte banks from top nibble
// - banks one to seven go external
// - bank zero holds 1 Mbyte internal windows
// - bank fifteen goes to peripheral bridge
// - unassigned regions answer with abort
// - one decoder per master, same map except boot alias (masters 0 and 1 only)
// - zero region maps to three possible slaves
// - boot memory present at zero from reset
// - remap set puts first SRAM at zero
// - remap clear, select high: ROM at zero
// - remap clear, select low: chip-select zero
// - boot select captured at reset, not live
// - first megabyte reserved as boot alias
// - ROM, SRAMs, USB host at fixed bases
// - external boot: byte select, 16-bit, cs strobes
// - each chip select owns 256 Mbytes
// - system controller in topmost address range
package brd_pkg;

   // ----------------------------------------
   // address map
   // ----------------------------------------
   localparam int NUM_MASTERS = 6;
   localparam logic [3:0] BANK_INTERNAL = 4'h0;
   localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
   localparam logic [3:0] BANK_EXT_LAST = 4'h7;
   localparam logic [3:0] BANK_PERIPH = 4'hF;
   localparam logic [7:0] WIN_BOOT = 8'h00;
   localparam logic [7:0] WIN_ROM = 8'h01;
   localparam logic [7:0] WIN_SRAM_A = 8'h02;
   localparam logic [7:0] WIN_SRAM_B = 8'h03;
   localparam logic [7:0] WIN_USBH = 8'h05;
   localparam logic [31:0] SYSC_BASE = 32'hFFFFE800;
   localparam logic [31:0] SYSC_LAST = 32'hFFFFFFFF;

   // ----------------------------------------
   // external boot defaults for the static memory controller
   // ----------------------------------------
   localparam logic BOOT_BYTE_SELECT = 1'h1;
   localparam logic [1:0] BOOT_BUS_16 = 2'h1;
   localparam logic BOOT_RW_BY_CS = 1'h1;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [7:0] {
      TGT_SRAM_A = 8'h01,
      TGT_SRAM_B = 8'h02,
      TGT_ROM = 8'h04,
      TGT_USBH = 8'h08,
      TGT_EXT = 8'h10,
      TGT_PERIPH = 8'h20,
      TGT_ABORT = 8'h40
   } brd_target_e;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } brd_req_s;

   typedef struct packed {
      logic valid;
      brd_target_e target;
      logic [2:0] cs;
      logic [27:0] offset;
      logic sysc;
   } brd_route_s;

   typedef struct packed {
      logic byte_select;
      logic [1:0] bus_width;
      logic rw_by_cs;
   } brd_smc_cfg_s;

endpackage

// ==== brd_boot_state.sv ====
// brd_boot_state: holds captured boot select and remap control
// assumes remap set/clear pulses come from the matrix configuration logic
module brd_boot_state (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // controls
   input wire logic boot_select_pin_i,
   input wire logic remap_set_i,
   input wire logic remap_clr_i,
   // state
   output logic boot_rom_o,
   output logic remap_o,
   output logic captured_o
);

   logic boot_rom_r;
   logic captured_r;
   logic remap_r;

   // ----------------------------------------
   // pin capture on the first edge after release
   // ----------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         captured_r <= 1'h0;
      end else begin
         captured_r <= 1'h1;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         boot_rom_r <= 1'h0;
      end else if (!captured_r) begin
         boot_rom_r <= boot_select_pin_i;
      end
   end

   // ----------------------------------------
   // remap control, cleared by reset
   // ----------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         remap_r <= 1'h0;
      end else if (remap_set_i) begin
         remap_r <= 1'h1;
      end else if (remap_clr_i) begin
         remap_r <= 1'h0;
      end
   end

   assign boot_rom_o = boot_rom_r;
   assign remap_o = remap_r;
   assign captured_o = captured_r;

endmodule

// ==== brd_decoder.sv ====
// brd_decoder: first-level address decoder, one registered path per master
// assumes masters hold address valid one cycle; route answer is one cycle later
module brd_decoder (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // boot and remap controls
   input wire logic BOOT_SELECT_PIN_I,
   input wire logic REMAP_SET_I,
   input wire logic REMAP_CLR_I,
   // master requests
   input brd_pkg::brd_req_s REQ_I [brd_pkg::NUM_MASTERS],
   // routes
   output brd_pkg::brd_route_s ROUTE_O [brd_pkg::NUM_MASTERS],
   // status
   output logic REMAP_O,
   output logic BOOT_ROM_O,
   output logic READY_O,
   output brd_pkg::brd_smc_cfg_s SMC_CFG_O
);

   logic boot_rom;
   logic remap;
   logic captured;
   brd_pkg::brd_route_s route_r [brd_pkg::NUM_MASTERS];
   brd_pkg::brd_route_s route_nxt [brd_pkg::NUM_MASTERS];
   brd_pkg::brd_smc_cfg_s smc_cfg_r;

   brd_boot_state u_boot (
      .CLK_I(CLK_I),
      .RST_N_I(RST_N_I),
      .boot_select_pin_i(BOOT_SELECT_PIN_I),
      .remap_set_i(REMAP_SET_I),
      .remap_clr_i(REMAP_CLR_I),
      .boot_rom_o(boot_rom),
      .remap_o(remap),
      .captured_o(captured)
   );

   // ----------------------------------------
   // decode function shared by every master
   // ----------------------------------------
   function automatic brd_pkg::brd_route_s decode(input brd_pkg::brd_req_s req,
                                                   input logic rmp, input logic brom,
                                                   input logic primary);
      brd_pkg::brd_route_s r;
      logic [3:0] bank;
      logic [7:0] win;
      r = '0;
      bank = req.addr[31:28];
      win = req.addr[27:20];
      r.valid = req.valid;
      r.offset = {8'h00, req.addr[19:0]};
      r.target = brd_pkg::TGT_ABORT;
      if (bank == brd_pkg::BANK_INTERNAL) begin
         if (win == brd_pkg::WIN_BOOT && primary) begin
            if (rmp) begin
               r.target = brd_pkg::TGT_SRAM_A;
            end else if (brom) begin
               r.target = brd_pkg::TGT_ROM;
            end else begin
               r.target = brd_pkg::TGT_EXT;
               r.cs = 3'h0;
               r.offset = req.addr[27:0];
            end
         end else if (win == brd_pkg::WIN_ROM) begin
            r.target = brd_pkg::TGT_ROM;
         end else if (win == brd_pkg::WIN_SRAM_A) begin
            r.target = brd_pkg::TGT_SRAM_A;
         end else if (win == brd_pkg::WIN_SRAM_B) begin
            r.target = brd_pkg::TGT_SRAM_B;
         end else if (win == brd_pkg::WIN_USBH) begin
            r.target = brd_pkg::TGT_USBH;
         end
      end else if (bank >= brd_pkg::BANK_EXT_FIRST && bank <= brd_pkg::BANK_EXT_LAST) begin
         r.target = brd_pkg::TGT_EXT;
         r.cs = 3'(bank - brd_pkg::BANK_EXT_FIRST);
         r.offset = req.addr[27:0];
      end else if (bank == brd_pkg::BANK_PERIPH) begin
         r.target = brd_pkg::TGT_PERIPH;
         r.offset = req.addr[27:0];
         r.sysc = (req.addr >= brd_pkg::SYSC_BASE);
      end
      return r;
   endfunction

   // ----------------------------------------
   // per-master decoders
   // ----------------------------------------
   always_comb begin
      for (int m = 0; m < brd_pkg::NUM_MASTERS; m++) begin
         // processor instruction and data ports see the boot alias
         route_nxt[m] = decode(REQ_I[m], remap, boot_rom, (m < 2));
         route_nxt[m].valid = REQ_I[m].valid & captured;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int m = 0; m < brd_pkg::NUM_MASTERS; m++) begin
            route_r[m] <= '0;
         end
      end else begin
         for (int m = 0; m < brd_pkg::NUM_MASTERS; m++) begin
            route_r[m] <= route_nxt[m];
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign ROUTE_O = route_r;
   assign REMAP_O = remap;
   assign BOOT_ROM_O = boot_rom;
   assign READY_O = captured;

   // ----------------------------------------
   // static controller boot defaults
   // ----------------------------------------
   // held in a register so the data output comes from a flip-flop;
   // software reprograms the controller itself, not this default
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         smc_cfg_r.byte_select <= brd_pkg::BOOT_BYTE_SELECT;
         smc_cfg_r.bus_width <= brd_pkg::BOOT_BUS_16;
         smc_cfg_r.rw_by_cs <= brd_pkg::BOOT_RW_BY_CS;
      end else begin
         smc_cfg_r.byte_select <= brd_pkg::BOOT_BYTE_SELECT;
         smc_cfg_r.bus_width <= brd_pkg::BOOT_BUS_16;
         smc_cfg_r.rw_by_cs <= brd_pkg::BOOT_RW_BY_CS;
      end
   end

   assign SMC_CFG_O = smc_cfg_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_abort_unused;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[2].valid && captured && REQ_I[2].addr[31:28] > 4'h7 && REQ_I[2].addr[31:28] < 4'hF)
      |=> ROUTE_O[2].target == brd_pkg::TGT_ABORT;
   endproperty
   a_abort_unused: assert property (p_abort_unused) else $error("unused bank not aborted");

   property p_ext_cs;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[3].valid && captured && REQ_I[3].addr[31:28] == 4'h3)
      |=> ROUTE_O[3].target == brd_pkg::TGT_EXT && ROUTE_O[3].cs == 3'h2;
   endproperty
   a_ext_cs: assert property (p_ext_cs) else $error("external bank chip select wrong");

   property p_periph;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[1].valid && captured && REQ_I[1].addr[31:28] == 4'hF)
      |=> ROUTE_O[1].target == brd_pkg::TGT_PERIPH;
   endproperty
   a_periph: assert property (p_periph) else $error("bank fifteen not peripheral");

   property p_remap_zero;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[0].valid && captured && remap && REQ_I[0].addr[31:20] == 12'h000)
      |=> ROUTE_O[0].target == brd_pkg::TGT_SRAM_A;
   endproperty
   a_remap_zero: assert property (p_remap_zero) else $error("remap zero not sram");

   property p_rom_zero;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[0].valid && captured && !remap && boot_rom && REQ_I[0].addr[31:20] == 12'h000)
      |=> ROUTE_O[0].target == brd_pkg::TGT_ROM;
   endproperty
   a_rom_zero: assert property (p_rom_zero) else $error("rom boot alias wrong");

   property p_ext_zero;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[1].valid && captured && !remap && !boot_rom && REQ_I[1].addr[31:20] == 12'h000)
      |=> ROUTE_O[1].target == brd_pkg::TGT_EXT && ROUTE_O[1].cs == 3'h0;
   endproperty
   a_ext_zero: assert property (p_ext_zero) else $error("external boot alias wrong");

   property p_fixed_second_internal_sram;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[4].valid && captured && REQ_I[4].addr[31:20] == 12'h003)
      |=> ROUTE_O[4].target == brd_pkg::TGT_SRAM_B;
   endproperty
   a_fixed_second_internal_sram: assert property (p_fixed_second_internal_sram) else $error("second sram base wrong");

   property p_boot_stable;
      @(posedge CLK_I) disable iff (!RST_N_I)
      captured |=> $stable(boot_rom);
   endproperty
   a_boot_stable: assert property (p_boot_stable) else $error("boot select changed after capture");

   // ----------------------------------------
   // boot capture and remap control checks
   // ----------------------------------------
   // capture is the edge at which ready first rises after reset
   sequence s_capture;
      !captured ##1 captured;
   endsequence

   property p_boot_capture;
      @(posedge CLK_I) disable iff (!RST_N_I)
      s_capture
      |-> boot_rom == $past(BOOT_SELECT_PIN_I);
   endproperty
   a_boot_capture: assert property (p_boot_capture) else $error("boot select not captured");

   property p_remap_set;
      @(posedge CLK_I) disable iff (!RST_N_I)
      REMAP_SET_I
      |=> remap;
   endproperty
   a_remap_set: assert property (p_remap_set) else $error("remap not set");

   property p_remap_clr;
      @(posedge CLK_I) disable iff (!RST_N_I)
      REMAP_CLR_I && !REMAP_SET_I
      |=> !remap;
   endproperty
   a_remap_clr: assert property (p_remap_clr) else $error("remap not cleared");

   // remap holds until an explicit clear
   sequence s_remap_kept;
      remap && !REMAP_CLR_I;
   endsequence

   property p_remap_hold;
      @(posedge CLK_I) disable iff (!RST_N_I)
      s_remap_kept
      |=> remap;
   endproperty
   a_remap_hold: assert property (p_remap_hold) else $error("remap lost");

   // ----------------------------------------
   // fixed windows and region checks
   // ----------------------------------------
   property p_rom_base;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[2].valid && captured && REQ_I[2].addr[31:20] == 12'h001)
      |=> ROUTE_O[2].target == brd_pkg::TGT_ROM;
   endproperty
   a_rom_base: assert property (p_rom_base) else $error("rom base wrong");

   property p_usbh_base;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[1].valid && captured && REQ_I[1].addr[31:20] == 12'h005)
      |=> ROUTE_O[1].target == brd_pkg::TGT_USBH;
   endproperty
   a_usbh_base: assert property (p_usbh_base) else $error("usb host base wrong");

   property p_alias_other;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[3].valid && captured && REQ_I[3].addr[31:20] == 12'h000)
      |=> ROUTE_O[3].target == brd_pkg::TGT_ABORT;
   endproperty
   a_alias_other: assert property (p_alias_other) else $error("alias seen by dma master");

   property p_sysc_top;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[0].valid && captured && REQ_I[0].addr >= brd_pkg::SYSC_BASE)
      |=> ROUTE_O[0].sysc;
   endproperty
   a_sysc_top: assert property (p_sysc_top) else $error("system controller not flagged");

   property p_ext_offset;
      @(posedge CLK_I) disable iff (!RST_N_I)
      (REQ_I[5].valid && captured && REQ_I[5].addr[31:28] >= 4'h1
       && REQ_I[5].addr[31:28] <= 4'h7)
      |=> ROUTE_O[5].offset == $past(REQ_I[5].addr[27:0]);
   endproperty
   a_ext_offset: assert property (p_ext_offset) else $error("external offset wrong");

   // ----------------------------------------
   // per-master path checks
   // ----------------------------------------
   for (genvar g = 0; g < brd_pkg::NUM_MASTERS; g++) begin : g_path
      property p_valid_follows;
         @(posedge CLK_I) disable iff (!RST_N_I)
         REQ_I[g].valid && captured
         |=> ROUTE_O[g].valid;
      endproperty
      a_valid_follows: assert property (p_valid_follows) else $error("taken request lost");

      // nothing is routed before the strap is captured
      property p_masked;
         @(posedge CLK_I) disable iff (!RST_N_I)
         !captured
         |=> !ROUTE_O[g].valid;
      endproperty
      a_masked: assert property (p_masked) else $error("route before ready");
   end

endmodule

// ==== brd_master_model.sv ====
// brd_master_model: stands in for the bus masters that face the decoder
// assumes the bench sets one command at a time, off the rising clock edge
module brd_master_model (
   // command from the bench
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_master_i,
   input wire logic [31:0] cmd_addr_i,
   // requests towards the decoder
   output brd_pkg::brd_req_s req_o [brd_pkg::NUM_MASTERS]
);
   // ----------------------------------------
   // one master issues, the others show a scrambled idle address
   // ----------------------------------------
   always_comb begin
      for (int m = 0; m < brd_pkg::NUM_MASTERS; m++) begin
         req_o[m].valid = cmd_valid_i && (cmd_master_i == m[2:0]);
         req_o[m].addr = req_o[m].valid ? cmd_addr_i : ~cmd_addr_i;
      end
   end
endmodule

// ==== test_boot_remap_address_decoder.sv ====
// test_boot_remap_address_decoder: self-checking bench of the decoder
// assumes the design registers its answer to a request at the edge that takes it
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module test_boot_remap_address_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, pin = 1, rset = 0, rclr = 0, cmd_valid = 0;
   logic [2:0] cmd_master = 3'h0;
   logic [31:0] cmd_addr = 32'h0;
   brd_pkg::brd_req_s req [brd_pkg::NUM_MASTERS];
   brd_pkg::brd_route_s route [brd_pkg::NUM_MASTERS];
   brd_pkg::brd_smc_cfg_s smc;
   logic remap, brom, ready;
   int failures = 0, n_checks = 0, cycles = 0;
   brd_pkg::brd_route_s r;

   always #4 clk = ~clk;
   brd_master_model masters (.cmd_valid_i(cmd_valid), .cmd_master_i(cmd_master),
      .cmd_addr_i(cmd_addr), .req_o(req));
   brd_decoder dut (.CLK_I(clk), .RST_N_I(rst_n), .BOOT_SELECT_PIN_I(pin),
      .REMAP_SET_I(rset), .REMAP_CLR_I(rclr), .REQ_I(req), .ROUTE_O(route),
      .REMAP_O(remap), .BOOT_ROM_O(brom), .READY_O(ready), .SMC_CFG_O(smc));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic tally_and_finish();
      if (failures == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // valid is left high so requests run back to back
   task automatic probe(input int m, input logic [31:0] a, input brd_pkg::brd_target_e t);
      cmd_valid = 1;
      cmd_master = m[2:0];
      cmd_addr = a;
      @(negedge clk);
      r = route[m];
      `CHK("valid", 1'h1, r.valid)
      `CHK("target", t, r.target)
   endtask

   task automatic do_reset(input logic p);
      cmd_valid = 0;
      rst_n = 0;
      pin = p;
      repeat (6) @(negedge clk);
      `CHK("route in reset", 1'h0, route[0].valid)
      `CHK("remap in reset", 1'h0, remap)
      `CHK("ready in reset", 1'h0, ready)
      rst_n = 1;
      @(negedge clk);
      `CHK("ready", 1'h1, ready)
      `CHK("boot select", p, brom)
      pin = ~p;
   endtask

   task automatic pulse_remap(input logic set);
      rset = set;
      rclr = ~set;
      @(negedge clk);
      rset = 0;
      rclr = 0;
      @(negedge clk);
      `CHK("remap", set, remap)
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_map();
      for (int b = 1; b < 8; b++) begin
         probe(b % 6, {b[3:0], 28'hABCDE14}, brd_pkg::TGT_EXT);
         `CHK("chip select", b[2:0] - 3'h1, r.cs)
         `CHK("ext offset", 28'hABCDE14, r.offset)
      end
      for (int b = 8; b < 15; b++)
         probe(b % 6, {b[3:0], 28'h0000010}, brd_pkg::TGT_ABORT);
      probe(2, 32'h00100040, brd_pkg::TGT_ROM);
      `CHK("int offset", 20'h00040, r.offset[19:0])
      probe(3, 32'h002FFFFC, brd_pkg::TGT_SRAM_A);
      probe(4, 32'h00300000, brd_pkg::TGT_SRAM_B);
      probe(1, 32'h00500008, brd_pkg::TGT_USBH);
      probe(0, 32'h00400000, brd_pkg::TGT_ABORT);
      probe(5, 32'h00600000, brd_pkg::TGT_ABORT);
      probe(2, 32'h00000100, brd_pkg::TGT_ABORT);
      probe(1, 32'hF0001234, brd_pkg::TGT_PERIPH);
      `CHK("sysc low", 1'h0, r.sysc)
      probe(1, 32'hFFFFE7FC, brd_pkg::TGT_PERIPH);
      `CHK("sysc below", 1'h0, r.sysc)
      probe(0, 32'hFFFFE800, brd_pkg::TGT_PERIPH);
      `CHK("sysc base", 1'h1, r.sysc)
      probe(2, 32'hFFFFFFFC, brd_pkg::TGT_PERIPH);
      `CHK("sysc top", 1'h1, r.sysc)
      cmd_valid = 0;
      @(negedge clk);
      `CHK("route drops", 1'h0, route[2].valid)
   endtask

   // boot select was high at reset and the live pin is now low
   task automatic t_alias();
      probe(0, 32'h00000000, brd_pkg::TGT_ROM);
      probe(1, 32'h000FFFFC, brd_pkg::TGT_ROM);
      cmd_valid = 0;
      pulse_remap(1);
      probe(0, 32'h00000010, brd_pkg::TGT_SRAM_A);
      probe(1, 32'h00100000, brd_pkg::TGT_ROM);
      probe(3, 32'h00000000, brd_pkg::TGT_ABORT);
      cmd_valid = 0;
      pulse_remap(0);
      probe(1, 32'h00000004, brd_pkg::TGT_ROM);
      cmd_valid = 0;
      pulse_remap(1);
   endtask

   task automatic t_ext_boot();
      probe(0, 32'h00000020, brd_pkg::TGT_EXT);
      `CHK("alias cs", 3'h0, r.cs)
      probe(1, 32'h000FFFF0, brd_pkg::TGT_EXT);
      `CHK("alias offset", 28'h00FFFF0, r.offset)
      `CHK("smc cfg", {brd_pkg::BOOT_BYTE_SELECT, brd_pkg::BOOT_BUS_16,
         brd_pkg::BOOT_RW_BY_CS}, smc)
      cmd_valid = 0;
      pulse_remap(1);
      probe(1, 32'h00000020, brd_pkg::TGT_SRAM_A);
      cmd_valid = 0;
   endtask

   // ----------------------------------------
   // main sequence and hang guard
   // ----------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         tally_and_finish();
      end
   end

   initial begin
      @(negedge clk);
      do_reset(1);
      t_map();
      t_alias();
      do_reset(0);
      t_ext_boot();
      tally_and_finish();
   end
endmodule
